/* logic/adc_seq_pkg.sv */
// constants for the converter sequencing host
// assumes one 125 MHz system clock; device pins sampled through synchronisers
// Contract
// - after standby release, wait 100 us before any conversion start
// - if standby-exit delay is missed, discard first result or reset
// - leaving shutdown, wait 50 ms after standby rise before reset rises
// - hold reset high at least 50 ns during shutdown exit
// - after reset falls, wait 25 us before any conversion start
// - no oversampling, parallel or dual-line-during: cycle at least 3 us
// - no oversampling, dual-line serial after conversion: cycle 3.8 us
// - no oversampling, single-line serial after conversion: cycle 5.5 us
// - chip select falls no later than read strobe falls
// - read strobe rises no later than chip select rises
// - at least 1 us acquisition from busy fall to next start rise
package adc_seq_pkg;
  localparam int CLK_MHZ        = 125;
  localparam int CLK_PERIOD_NS  = 8;
  localparam int STANDBY_N_EXIT_US   = 100;
  localparam int SD_RST_MS      = 50;
  localparam int RST_HIGH_NS    = 50;
  localparam int RST_CONV_US    = 25;
  localparam int ACQ_US         = 1;
  localparam int CYC_PAR_NS     = 3000;
  localparam int CYC_SER2_NS    = 3800;
  localparam int CYC_SER1_NS    = 5500;
  localparam int STROBE_NS      = 15;
  // least times round up to whole cycles
  localparam int STANDBY_N_EXIT_CYC  = STANDBY_N_EXIT_US * CLK_MHZ;
  localparam int SD_RST_CYC     = SD_RST_MS * 1000 * CLK_MHZ;
  localparam int RST_HIGH_CYC   =
    (RST_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CONV_CYC   = RST_CONV_US * CLK_MHZ;
  localparam int ACQ_CYC        = ACQ_US * CLK_MHZ;
  localparam int CYC_PAR_CYC    =
    (CYC_PAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_SER2_CYC   =
    (CYC_SER2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_SER1_CYC   =
    (CYC_SER1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC     =
    (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W          = 24;
  localparam int NUM_CH         = 4;
  localparam int WORD_W         = 16;
  localparam logic [1:0] READ_PAR  = 2'h0;
  localparam logic [1:0] READ_SER2 = 2'h1;
  localparam logic [1:0] READ_SER1 = 2'h2;
  typedef enum logic [3:0] {
    S_OFF, S_WAKE, S_RST_WAIT, S_RST_HIGH, S_RST_SETTLE, S_IDLE,
    S_CONV, S_CS, S_RD_LOW, S_RD_HIGH, S_CS_HIGH, S_CYC
  } seq_state_e;
endpackage

/* logic/adc_result_mem.sv */
// four-word result store for one conversion frame
// assumes one writer and one reader on the same clock
`timescale 1ns/1ps
module adc_result_mem #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 16
) (
  input  wire logic                     clk_sys,
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]         wrData,
  input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic      [WIDTH-1:0]         rdData
);
  logic [WIDTH-1:0] store [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk_sys) begin
    rdData <= store[rdAddr];
  end
endmodule

/* logic/adc_seq_host.sv */
// host sequencer: power-up, start, busy wait and separate-strobe parallel read
// assumes busy and data bus come from the converter pins, asynchronous here
`timescale 1ns/1ps
module adc_seq_host
  import adc_seq_pkg::*;
#(
  parameter int WAKE_CYC = SD_RST_CYC,
  parameter int STANDBY_N_CYC = STANDBY_N_EXIT_CYC
) (
  input  wire logic                           clk_sys,
  input  wire logic                           rst_b,
  input  wire logic                           enable,
  input  wire logic                           startReq,
  input  wire logic [1:0]                     readMode,
  input  wire logic                           busyPin,
  input  wire logic [adc_seq_pkg::WORD_W-1:0] parallelDataBus,
  output logic                                standby_n,
  output logic                                resetPin,
  output logic                                conv_start_group_a,
  output logic                                conv_start_group_b,
  output logic                                cs_n,
  output logic                                rd_n,
  output logic                                resultValid,
  output logic [1:0]                          resultChannel,
  output logic [adc_seq_pkg::WORD_W-1:0]      resultData,
  output logic                                ready
);
  import adc_seq_pkg::*;

  seq_state_e       state;
  logic [CNT_W-1:0] timer;
  logic [CNT_W-1:0] cycTimer;
  logic [CNT_W-1:0] acqTimer;
  logic [1:0]       chan;
  logic             busyMeta;
  logic             busySync;
  logic             busyLast;
  logic [WORD_W-1:0] dataMeta;
  logic [WORD_W-1:0] dataSync;
  logic             memWr;
  logic [1:0]       memWrAddr;
  logic [WORD_W-1:0] memRd;
  logic             memRdPend;
  logic             memRdDly;
  logic [1:0]       memRdCh;
  logic             rdRise;

  function automatic logic [CNT_W-1:0] cycle_min(input logic [1:0] mode);
    unique case (mode)
      READ_SER2: cycle_min = CNT_W'(CYC_SER2_CYC);
      READ_SER1: cycle_min = CNT_W'(CYC_SER1_CYC);
      default:   cycle_min = CNT_W'(CYC_PAR_CYC);
    endcase
  endfunction

  // busy and data are the converter's, so two flops before use
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busyMeta <= 1'b0;
      busySync <= 1'b0;
      busyLast <= 1'b0;
      dataMeta <= '0;
      dataSync <= '0;
    end else begin
      busyMeta <= busyPin;
      busySync <= busyMeta;
      busyLast <= busySync;
      dataMeta <= parallelDataBus;
      dataSync <= dataMeta;
    end
  end

  // cycle period counter restarts at each start edge
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cycTimer <= '0;
    end else if (state == S_IDLE && enable && startReq
                 && cycTimer >= cycle_min(readMode)
                 && acqTimer >= CNT_W'(ACQ_CYC)) begin
      cycTimer <= CNT_W'(1);
    end else if (cycTimer != {CNT_W{1'b1}}) begin
      cycTimer <= cycTimer + CNT_W'(1);
    end
  end

  // acquisition counter restarts at busy fall
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      acqTimer <= {CNT_W{1'b1}};
    end else if (busyLast && !busySync) begin
      acqTimer <= '0;
    end else if (acqTimer != {CNT_W{1'b1}}) begin
      acqTimer <= acqTimer + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state              <= S_OFF;
      timer              <= '0;
      standby_n          <= 1'b0;
      resetPin           <= 1'b0;
      conv_start_group_a <= 1'b0;
      conv_start_group_b <= 1'b0;
      cs_n               <= 1'b1;
      rd_n               <= 1'b1;
      chan               <= '0;
      ready              <= 1'b0;
    end else begin
      timer <= timer + CNT_W'(1);
      unique case (state)
        S_OFF: begin
          if (enable) begin
            standby_n <= 1'b1;
            timer     <= '0;
            state     <= S_WAKE;
          end
        end
        S_WAKE: begin
          // reference settle; covers the standby-exit delay too
          if (timer >= CNT_W'(WAKE_CYC - 1)
              && timer >= CNT_W'(STANDBY_N_CYC - 1)) begin
            resetPin <= 1'b1;
            timer    <= '0;
            state    <= S_RST_HIGH;
          end
        end
        S_RST_HIGH: begin
          if (timer >= CNT_W'(RST_HIGH_CYC - 1)) begin
            resetPin <= 1'b0;
            timer    <= '0;
            state    <= S_RST_SETTLE;
          end
        end
        S_RST_SETTLE: begin
          // reset always issued, so no first result needs dropping
          if (timer >= CNT_W'(RST_CONV_CYC - 1)) begin
            ready <= 1'b1;
            state <= S_IDLE;
          end
        end
        S_IDLE: begin
          if (!enable) begin
            standby_n <= 1'b0;
            ready     <= 1'b0;
            state     <= S_OFF;
          end else if (startReq && cycTimer >= cycle_min(readMode)
                       && acqTimer >= CNT_W'(ACQ_CYC)) begin
            conv_start_group_a <= 1'b1;
            conv_start_group_b <= 1'b1;
            ready <= 1'b0;
            timer <= '0;
            state <= S_CONV;
          end
        end
        S_CONV: begin
          if (timer >= CNT_W'(STROBE_CYC - 1)) begin
            conv_start_group_a <= 1'b0;
            conv_start_group_b <= 1'b0;
          end
          // busy fall means all four results can be read
          if (timer > CNT_W'(STROBE_CYC + 2) && !busySync) begin
            conv_start_group_a <= 1'b0;
            conv_start_group_b <= 1'b0;
            cs_n  <= 1'b0;
            chan  <= '0;
            state <= S_CS;
          end
        end
        S_CS: begin
          rd_n  <= 1'b0;
          timer <= '0;
          state <= S_RD_LOW;
        end
        S_RD_LOW: begin
          // extra cycles cover the two-flop data path
          if (timer >= CNT_W'(STROBE_CYC + 2)) begin
            rd_n  <= 1'b1;
            timer <= '0;
            state <= S_RD_HIGH;
          end
        end
        S_RD_HIGH: begin
          if (timer >= CNT_W'(STROBE_CYC - 1)) begin
            if (chan == 2'(NUM_CH - 1)) begin
              cs_n  <= 1'b1;
              state <= S_CYC;
            end else begin
              chan  <= chan + 2'h1;
              rd_n  <= 1'b0;
              timer <= '0;
              state <= S_RD_LOW;
            end
          end
        end
        S_CYC: begin
          ready <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_OFF;
      endcase
    end
  end

  assign rdRise = (state == S_RD_LOW) && (timer >= CNT_W'(STROBE_CYC + 2));

  // capture word while strobe is still low
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      memWr     <= 1'b0;
      memWrAddr <= '0;
    end else begin
      memWr     <= rdRise;
      memWrAddr <= chan;
    end
  end

  logic [WORD_W-1:0] capData;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      capData <= '0;
    end else if (rdRise) begin
      capData <= dataSync;
    end
  end

  adc_result_mem #(.DEPTH(NUM_CH), .WIDTH(WORD_W)) uMem (
    .clk_sys (clk_sys),
    .wrEn    (memWr),
    .wrAddr  (memWrAddr),
    .wrData  (capData),
    .rdAddr  (memWrAddr),
    .rdData  (memRd)
  );

  // words stream out one per channel after store
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      memRdPend     <= 1'b0;
      memRdDly      <= 1'b0;
      memRdCh       <= '0;
      resultValid   <= 1'b0;
      resultChannel <= '0;
      resultData    <= '0;
    end else begin
      // the store read lags its write by a cycle, so wait one more
      memRdPend     <= memWr;
      memRdDly      <= memRdPend;
      memRdCh       <= memWrAddr;
      resultValid   <= memRdDly;
      if (memRdDly) begin
        resultChannel <= memRdCh;
        resultData    <= memRd;
      end
    end
  end

  property p_cs_before_rd;
    @(posedge clk_sys) disable iff (!rst_b) !rd_n |-> !cs_n;
  endproperty
  a_cs_before_rd: assert property (p_cs_before_rd)
    else $error("read strobe low without chip select");
  property p_rd_before_cs;
    @(posedge clk_sys) disable iff (!rst_b) $rose(cs_n) |-> rd_n && $past(rd_n);
  endproperty
  a_rd_before_cs: assert property (p_rd_before_cs)
    else $error("chip select rose first");
  property p_rst_width;
    @(posedge clk_sys) disable iff (!rst_b) $rose(resetPin) |-> resetPin[*7];
  endproperty
  a_rst_width: assert property (p_rst_width)
    else $error("reset pulse short");
  property p_start_acq;
    @(posedge clk_sys) disable iff (!rst_b)
      $rose(conv_start_group_a) |-> $past(acqTimer) >= CNT_W'(ACQ_CYC);
  endproperty
  a_start_acq: assert property (p_start_acq)
    else $error("acquisition too short");
  property p_start_cycle;
    @(posedge clk_sys) disable iff (!rst_b) $rose(conv_start_group_a)
      |-> $past(cycTimer) >= cycle_min($past(readMode));
  endproperty
  a_start_cycle: assert property (p_start_cycle)
    else $error("cycle too short");
  property p_start_pair;
    @(posedge clk_sys) disable iff (!rst_b)
      conv_start_group_a == conv_start_group_b;
  endproperty
  a_start_pair: assert property (p_start_pair)
    else $error("start lines split");
endmodule

/* test/adc_dev_model.sv */
// behavioural converter: busy timing and four-word parallel read
// assumes the host raises both conversion starts together
`timescale 1ns/1ps
module adc_dev_model #(
  parameter int CONV_CYC = 250
) (
  input  wire logic        clk_sys,
  input  wire logic        convA,
  input  wire logic        convB,
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  output logic             busy,
  output logic [15:0]      dataBus
);
  logic [9:0]  frame;
  logic [1:0]  ch;
  logic [15:0] held;

  initial begin
    busy = 1'b0;
    dataBus = 16'h0000;
    held = 16'h0000;
    frame = 10'h000;
    ch = 2'h0;
  end

  // a second start edge during a conversion is ignored, as on the part
  always @(posedge convA or posedge convB) begin
    if (convA && convB && !busy) begin
      #5 busy = 1'b1;
      repeat (CONV_CYC) @(posedge clk_sys);
      frame = frame + 10'h001;
      busy = 1'b0;
    end
  end

  // each burst starts at channel 0 when chip select falls
  always @(negedge cs_n) begin
    ch = 2'h0;
  end

  always @(negedge rd_n) begin
    if (!cs_n) begin
      held = {4'h5, frame, ch};
      #10 dataBus = held;
    end
  end

  // released bus keeps the held word for 3 ns after rd_n rises, then shows the inverse
  always @(posedge rd_n) begin
    ch = ch + 2'h1;
    #3 dataBus = ~held;
  end

  always @(posedge cs_n) begin
    #6 dataBus = ~held;
  end
endmodule

/* test/adc_conversion_sequencing_bench.sv */
// self-checking bench for the converter sequencing host
// assumes the behavioural converter model stands on the far side
`timescale 1ns/1ps
module adc_conversion_sequencing_bench;
  import adc_seq_pkg::*;
  localparam int WAKE = 20;
  localparam int STANDBY_N = 10;
  logic        clk_sys;
  logic        rst_b;
  logic        enable;
  logic        startReq;
  logic [1:0]  readMode;
  logic        busy;
  logic [15:0] dataBus;
  logic        standby_n;
  logic        resetPin;
  logic        convA;
  logic        convB;
  logic        cs_n;
  logic        rd_n;
  logic        resultValid;
  logic [1:0]  resultChannel;
  logic [15:0] resultData;
  logic        ready;
  int          errors = 0;
  int          n_tests = 0;
  int          nFrame = 0;
  int          sStby = 0;
  int          sRst = 0;
  int          hRst = 0;
  int          sBusy = 100000;
  int          sConv = 100000;
  logic        pStby = 0, pRst = 0, pConv = 0, pBusy = 0;
  logic        pCs = 1, pRd = 1;

  adc_seq_host #(.WAKE_CYC(WAKE), .STANDBY_N_CYC(STANDBY_N)) uut (
    .clk_sys(clk_sys), .rst_b(rst_b), .enable(enable),
    .startReq(startReq), .readMode(readMode), .busyPin(busy),
    .parallelDataBus(dataBus), .standby_n(standby_n),
    .resetPin(resetPin), .conv_start_group_a(convA),
    .conv_start_group_b(convB), .cs_n(cs_n), .rd_n(rd_n),
    .resultValid(resultValid), .resultChannel(resultChannel),
    .resultData(resultData), .ready(ready));

  adc_dev_model #(.CONV_CYC(250)) dev (
    .clk_sys(clk_sys), .convA(convA), .convB(convB), .cs_n(cs_n),
    .rd_n(rd_n), .busy(busy), .dataBus(dataBus));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // 0: ready high, 1: result pulse, 2: back in standby
  task automatic wait_hi(input int sel);
    int i;
    for (i = 0; i < 8000; i++) begin
      if ((sel == 0 && ready === 1'b1) || (sel == 1 && resultValid === 1'b1)
          || (sel == 2 && standby_n === 1'b0)) break;
      @(negedge clk_sys);
    end
    if (i >= 8000) begin
      check(16'h0000, 16'h0001);
      summarize();
    end
  endtask

  function automatic int min_cycle(input logic [1:0] m);
    return (m == READ_SER1) ? CYC_SER1_CYC :
           (m == READ_SER2) ? CYC_SER2_CYC : CYC_PAR_CYC;
  endfunction

  // watches the converter pins on the edge where they are settled
  always @(negedge clk_sys) begin
    sStby++;
    sRst++;
    sBusy++;
    sConv++;
    if (resetPin) hRst++;
    if (standby_n && !pStby) sStby = 0;
    if (resetPin && !pRst) begin
      check(16'(sStby >= WAKE), 16'h0001);
      hRst = 1;
    end
    if (!resetPin && pRst) begin
      check(16'(hRst >= RST_HIGH_CYC), 16'h0001);
      sRst = 0;
    end
    if (!busy && pBusy) sBusy = 0;
    if (convA && !pConv) begin
      check(16'(sStby >= STANDBY_N), 16'h0001);
      check(16'(sRst >= RST_CONV_CYC), 16'h0001);
      check(16'(sBusy >= ACQ_CYC), 16'h0001);
      check(16'(sConv >= min_cycle(readMode)), 16'h0001);
      sConv = 0;
    end
    if (!rd_n && pRd) check(16'(cs_n), 16'h0000);
    if (cs_n && !pCs) check(16'(rd_n), 16'h0001);
    {pStby, pRst, pConv, pBusy, pCs, pRd} =
      {standby_n, resetPin, convA, busy, cs_n, rd_n};
  end

  task automatic t_reset();
    check(16'({standby_n, resetPin, convA, convB}), 16'h0000);
    check(16'({cs_n, rd_n, ready, resultValid}), 16'h000c);
  endtask

  task automatic t_power();
    enable = 1'b1;
    wait_hi(0);
    check(16'(standby_n), 16'h0001);
    check(16'(hRst >= RST_HIGH_CYC), 16'h0001);
  endtask

  // start held high, so frames run back to back at the minimum spacing
  task automatic t_frames(input logic [1:0] mode, input int n);
    int f;
    int c;
    readMode = mode;
    startReq = 1'b1;
    for (f = 0; f < n; f++) begin
      nFrame++;
      for (c = 0; c < NUM_CH; c++) begin
        wait_hi(1);
        check(16'(resultChannel), 16'(c));
        check(resultData, {4'h5, nFrame[9:0], 2'(c)});
        if (f == n - 1 && c == NUM_CH - 1) startReq = 1'b0;
        @(negedge clk_sys);
      end
    end
  endtask

  task automatic t_standby();
    enable = 1'b0;
    wait_hi(2);
    check(16'({standby_n, cs_n}), 16'h0001);
  endtask

  initial begin
    rst_b = 1'b0;
    enable = 1'b0;
    startReq = 1'b0;
    readMode = READ_PAR;
    repeat (5) @(negedge clk_sys);
    t_reset();
    rst_b = 1'b1;
    @(negedge clk_sys);
    t_power();
    t_frames(READ_PAR, 2);
    t_frames(READ_SER2, 2);
    t_frames(READ_SER1, 2);
    t_standby();
    summarize();
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    check(16'h0000, 16'h0001);
    summarize();
  end
endmodule
